// ### hw/cie_core.sv
// Execution unit for a subset of an 8-bit core's instructions.
// Assumes a decoder presents one operation per start pulse and data
// memory read data arrives with it; stack top is supplied by the caller.
//
// Overview of operation
// - No-operation changes nothing; program counter just advances.
// - OR accumulator with memory or immediate; only zero flag updated.
// - Subroutine return loads program counter from stack top, flags kept.
// - Return with literal pops program counter and loads immediate to acc.
// - Interrupt return pops pc and sets the global interrupt enable.
// - Interrupt pending at interrupt return is serviced before main code.
// - Rotate left moves bits up, bit 7 wraps to bit 0, flags kept.
// - Accumulator rotate forms write accumulator and leave memory alone.
// - Rotate left via carry: old carry into bit 0, bit 7 into carry.
// - Rotate right moves bits down, bit 0 wraps to bit 7, flags kept.
// - Rotate right via carry: old carry into bit 7, bit 0 into carry.
// - Subtract with borrow: acc minus operand minus inverted carry.
// - Subtraction carry is 0 when negative, 1 when zero or positive.
// - Subtracts set wrap, zero, half carry, carry, sign, chain zero.
// - Decrement skip writes back and skips when result is zero.
// - Accumulator skip forms write acc, test it, leave memory unchanged.
// - Every skip instruction here takes two instruction cycles.
// - Set byte writes all ones; set bit forces one bit; flags kept.
// - Increment skip writes back and skips when result is zero.
// - Bit test skip skips when the selected bit is one.
// - Non-zero skip writes byte back and skips when it is non-zero.
// - Plain subtract: acc minus memory, no borrow, result to acc.
`timescale 1ns/10ps
`default_nettype none
`include "cie_regs.svh"

module cie_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [4:0] op_code,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] imm,
	input wire logic [2:0] bit_sel,
	input wire logic [12:0] stack_top,
	input wire logic int_pending,
	output logic [7:0] acc,
	output logic [5:0] flags,
	output logic [12:0] pc,
	output logic global_interrupt_enable,
	output logic mem_we,
	output logic [7:0] mem_wdata,
	output logic stack_pop,
	output logic int_service,
	output logic busy,
	output logic done
);

	// ------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------
	logic [7:0] opnd;
	logic [7:0] res;
	logic [8:0] diff;
	logic [4:0] half;
	logic [7:0] sel_mask;
	logic wr_acc;
	logic wr_mem;
	logic set_z;
	logic arith;
	logic new_c;
	logic upd_c;
	logic skip;
	logic is_skip;
	logic borrow_in;
	logic next_ovf;
	cie_pkg::cie_state_t state;
	// Every check below runs on this clock and is off in reset
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	assign sel_mask = 8'h01 << bit_sel;
	assign opnd = (op_code == `CIE_OP_OR_IMM ||
		op_code == `CIE_OP_SBB_IMM) ? imm : mem_rdata;
	// Borrow is the inverted carry only for the borrow forms
	assign borrow_in = (op_code == `CIE_OP_SUB_MEM) ? 1'b0 :
		~flags[`CIE_FLG_C];
	assign diff = {1'b0, acc} - {1'b0, opnd} - {8'h00, borrow_in};
	assign half = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, borrow_in};
	assign next_ovf = (acc[7] ^ opnd[7]) & (acc[7] ^ diff[7]);

	// Operation decode: result, destination and flag effects
	always_comb begin
		res = acc;
		wr_acc = 1'b0;
		wr_mem = 1'b0;
		set_z = 1'b0;
		arith = 1'b0;
		new_c = flags[`CIE_FLG_C];
		upd_c = 1'b0;
		skip = 1'b0;
		is_skip = 1'b0;
		case (op_code)
		`CIE_OP_OR_MEM, `CIE_OP_OR_IMM: begin
			res = acc | opnd;
			wr_acc = 1'b1;
			set_z = 1'b1;
		end
		`CIE_OP_OR_INTO_MEM: begin
			res = acc | mem_rdata;
			wr_mem = 1'b1;
			set_z = 1'b1;
		end
		`CIE_OP_LEAVE_SUB_LIT: begin
			res = imm;
			wr_acc = 1'b1;
		end
		`CIE_OP_ROTL, `CIE_OP_ROTL_ACC: begin
			res = {mem_rdata[6:0], mem_rdata[7]};
			wr_acc = (op_code == `CIE_OP_ROTL_ACC);
			wr_mem = ~wr_acc;
		end
		`CIE_OP_ROTLC, `CIE_OP_ROTLC_ACC: begin
			res = {mem_rdata[6:0], flags[`CIE_FLG_C]};
			new_c = mem_rdata[7];
			upd_c = 1'b1;
			wr_acc = (op_code == `CIE_OP_ROTLC_ACC);
			wr_mem = ~wr_acc;
		end
		`CIE_OP_ROTR, `CIE_OP_ROTR_ACC: begin
			res = {mem_rdata[0], mem_rdata[7:1]};
			wr_acc = (op_code == `CIE_OP_ROTR_ACC);
			wr_mem = ~wr_acc;
		end
		`CIE_OP_ROTRC, `CIE_OP_ROTRC_ACC: begin
			res = {flags[`CIE_FLG_C], mem_rdata[7:1]};
			new_c = mem_rdata[0];
			upd_c = 1'b1;
			wr_acc = (op_code == `CIE_OP_ROTRC_ACC);
			wr_mem = ~wr_acc;
		end
		`CIE_OP_SBB_MEM, `CIE_OP_SBB_IMM, `CIE_OP_SUB_MEM: begin
			res = diff[7:0];
			wr_acc = 1'b1;
			arith = 1'b1;
		end
		`CIE_OP_SBB_INTO_MEM: begin
			res = diff[7:0];
			wr_mem = 1'b1;
			arith = 1'b1;
		end
		`CIE_OP_DEC_SKIP, `CIE_OP_DEC_SKIP_ACC: begin
			res = mem_rdata - 8'h01;
			wr_acc = (op_code == `CIE_OP_DEC_SKIP_ACC);
			wr_mem = ~wr_acc;
			is_skip = 1'b1;
			skip = (res == 8'h00);
		end
		`CIE_OP_INC_SKIP, `CIE_OP_INC_SKIP_ACC: begin
			res = mem_rdata + 8'h01;
			wr_acc = (op_code == `CIE_OP_INC_SKIP_ACC);
			wr_mem = ~wr_acc;
			is_skip = 1'b1;
			skip = (res == 8'h00);
		end
		`CIE_OP_SET_BYTE: begin
			res = `CIE_ALL_ONES;
			wr_mem = 1'b1;
		end
		`CIE_OP_SET_BIT: begin
			res = mem_rdata | sel_mask;
			wr_mem = 1'b1;
		end
		`CIE_OP_BIT_SKIP: begin
			is_skip = 1'b1;
			skip = |(mem_rdata & sel_mask);
		end
		`CIE_OP_NZ_SKIP: begin
			res = mem_rdata;
			wr_mem = 1'b1;
			is_skip = 1'b1;
			skip = (mem_rdata != 8'h00);
		end
		// No-operation, plain return and interrupt return touch no data
		default: res = acc;
		endcase
	end

	wire accept = start & (state == cie_pkg::CIE_EXEC);
	wire is_return = (op_code == `CIE_OP_LEAVE_SUB) ||
		(op_code == `CIE_OP_LEAVE_SUB_LIT) ||
		(op_code == `CIE_OP_LEAVE_INT);

	// ------------------------------------------------------------
	// Architectural state
	// ------------------------------------------------------------
	// Accumulator
	always_ff @(posedge clk) begin
		if (rst)
			acc <= `CIE_RST_ACC;
		else if (accept && wr_acc)
			acc <= res;
	end

	// Flags; only arithmetic, OR and carry rotates touch them
	always_ff @(posedge clk) begin
		if (rst) begin
			flags <= `CIE_RST_FLAGS;
		end else if (accept) begin
			if (set_z || arith)
				flags[`CIE_FLG_Z] <= (res == 8'h00);
			if (upd_c)
				flags[`CIE_FLG_C] <= new_c;
			if (arith) begin
				flags[`CIE_FLG_C] <= ~diff[8];
				flags[`CIE_FLG_HALF] <= ~half[4];
				flags[`CIE_FLG_WRAP] <= next_ovf;
				flags[`CIE_FLG_SIGN] <= diff[7] ^ next_ovf;
				// Chained zero keeps multi-byte zero tests honest
				flags[`CIE_FLG_CHAIN] <= (res == 8'h00) &
					(op_code == `CIE_OP_SUB_MEM ||
					flags[`CIE_FLG_CHAIN]);
			end
		end
	end

	// Program counter: step, return, or skip over next word
	always_ff @(posedge clk) begin
		if (rst)
			pc <= `CIE_RST_PC;
		else if (accept && is_return)
			pc <= stack_top;
		else if (accept && skip)
			pc <= pc + 13'h0002;
		else if (accept)
			pc <= pc + 13'h0001;
	end

	// Global interrupt enable set by interrupt return
	always_ff @(posedge clk) begin
		if (rst)
			global_interrupt_enable <= 1'b0;
		else if (accept && op_code == `CIE_OP_LEAVE_INT)
			global_interrupt_enable <= 1'b1;
	end

	// Pending request after interrupt return goes to service first
	always_ff @(posedge clk) begin
		if (rst)
			int_service <= 1'b0;
		else
			int_service <= accept &&
				op_code == `CIE_OP_LEAVE_INT && int_pending;
	end

	// Memory write strobe and data, one cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_we <= 1'b0;
			mem_wdata <= 8'h00;
		end else begin
			mem_we <= accept & wr_mem;
			mem_wdata <= res;
		end
	end

	// Stack pop strobe
	always_ff @(posedge clk) begin
		if (rst)
			stack_pop <= 1'b0;
		else
			stack_pop <= accept & is_return;
	end

	// ------------------------------------------------------------
	// Cycle sequencing
	// ------------------------------------------------------------
	// Skip ops spend a dummy cycle; start is ignored meanwhile
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= cie_pkg::CIE_EXEC;
		end else begin
			case (state)
			cie_pkg::CIE_EXEC: begin
				if (accept && is_skip)
					state <= cie_pkg::CIE_DUMMY;
			end
			cie_pkg::CIE_DUMMY: state <= cie_pkg::CIE_EXEC;
			default: state <= cie_pkg::CIE_EXEC;
			endcase
		end
	end

	// Busy during dummy cycle, done when instruction completes
	always_ff @(posedge clk) begin
		if (rst) begin
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			busy <= accept & is_skip;
			done <= (accept & ~is_skip) |
				(state == cie_pkg::CIE_DUMMY);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_nop_still;
		(accept && op_code == `CIE_OP_NOP) |=>
		(acc == $past(acc) && flags == $past(flags) && !mem_we &&
		pc == $past(pc) + 13'h0001);
	endproperty
	a_nop_still: assert property (p_nop_still)
		else $error("nop changed state");
	property p_or_acc;
		(accept && op_code == `CIE_OP_OR_MEM) |=>
		(acc == ($past(acc) | $past(mem_rdata)) &&
		flags[`CIE_FLG_C] == $past(flags[`CIE_FLG_C]));
	endproperty
	a_or_acc: assert property (p_or_acc)
		else $error("or result wrong");
	property p_return_pc;
		(accept && op_code == `CIE_OP_LEAVE_SUB) |=>
		(pc == $past(stack_top) && stack_pop && flags == $past(flags));
	endproperty
	a_return_pc: assert property (p_return_pc)
		else $error("return pc wrong");
	property p_int_return_en;
		(accept && op_code == `CIE_OP_LEAVE_INT) |=>
		(global_interrupt_enable && int_service == $past(int_pending));
	endproperty
	a_int_return_en: assert property (p_int_return_en)
		else $error("interrupt return enable wrong");
	property p_rotl;
		(accept && op_code == `CIE_OP_ROTL) |=>
		(mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])});
	endproperty
	a_rotl: assert property (p_rotl)
		else $error("rotate left wrong");
	property p_sub_carry;
		(accept && op_code == `CIE_OP_SUB_MEM) |=>
		(flags[`CIE_FLG_C] == ($past(acc) >= $past(mem_rdata)));
	endproperty
	a_sub_carry: assert property (p_sub_carry)
		else $error("sub carry");
	sequence s_skip_taken;
		accept && is_skip && skip;
	endsequence
	sequence s_two_cycles;
		busy ##1 done;
	endsequence
	property p_skip_time;
		s_skip_taken |=> s_two_cycles;
	endproperty
	a_skip_time: assert property (p_skip_time)
		else $error("skip timing");
	property p_skip_pc;
		s_skip_taken |=> (pc == $past(pc) + 13'h0002);
	endproperty
	a_skip_pc: assert property (p_skip_pc)
		else $error("skip pc");
	property p_set_byte;
		(accept && op_code == `CIE_OP_SET_BYTE) |=>
		(mem_we && mem_wdata == 8'hff && flags == $past(flags));
	endproperty
	a_set_byte: assert property (p_set_byte)
		else $error("set byte");

endmodule
`default_nettype wire

// ### hw/cie_pkg.sv
// Types shared by the instruction execution subset.
// Assumes the constants header is on the include path.
`include "cie_regs.svh"

package cie_pkg;
	typedef enum logic {
		CIE_EXEC,
		CIE_DUMMY
	} cie_state_t;
endpackage

// ### hw/cie_regs.svh
// Constants for the instruction execution subset: opcodes, flag bit
// positions, reset values and cycle counts.
// Assumes inclusion by bare name from the package and the core.
`ifndef CIE_REGS_SVH
`define CIE_REGS_SVH

// Operation codes presented on op_code
`define CIE_OP_NOP 5'h00
`define CIE_OP_OR_MEM 5'h01
`define CIE_OP_OR_IMM 5'h02
`define CIE_OP_OR_INTO_MEM 5'h03
`define CIE_OP_LEAVE_SUB 5'h04
`define CIE_OP_LEAVE_SUB_LIT 5'h05
`define CIE_OP_LEAVE_INT 5'h06
`define CIE_OP_ROTL 5'h07
`define CIE_OP_ROTL_ACC 5'h08
`define CIE_OP_ROTLC 5'h09
`define CIE_OP_ROTLC_ACC 5'h0a
`define CIE_OP_ROTR 5'h0b
`define CIE_OP_ROTR_ACC 5'h0c
`define CIE_OP_ROTRC 5'h0d
`define CIE_OP_ROTRC_ACC 5'h0e
`define CIE_OP_SBB_MEM 5'h0f
`define CIE_OP_SBB_IMM 5'h10
`define CIE_OP_SBB_INTO_MEM 5'h11
`define CIE_OP_DEC_SKIP 5'h12
`define CIE_OP_DEC_SKIP_ACC 5'h13
`define CIE_OP_SET_BYTE 5'h14
`define CIE_OP_SET_BIT 5'h15
`define CIE_OP_INC_SKIP 5'h16
`define CIE_OP_INC_SKIP_ACC 5'h17
`define CIE_OP_BIT_SKIP 5'h18
`define CIE_OP_NZ_SKIP 5'h19
`define CIE_OP_SUB_MEM 5'h1a

// Flag positions in the flag word
`define CIE_FLG_C 0
`define CIE_FLG_HALF 1
`define CIE_FLG_Z 2
`define CIE_FLG_WRAP 3
`define CIE_FLG_SIGN 4
`define CIE_FLG_CHAIN 5

// Reset values and the all-ones byte that set byte writes
`define CIE_RST_ACC 8'h00
`define CIE_RST_PC 13'h0000
`define CIE_RST_FLAGS 6'h00
`define CIE_ALL_ONES 8'hff

// Cycle counts: skip instructions take two, the rest one
`define CIE_CYC_SKIP 2'h2
`define CIE_CYC_PLAIN 2'h1

`endif

// ### test/cie_core_test.sv
// Self-checking bench for the instruction execution subset.
// Assumes cie_regs.svh on the include path; the bench plays decoder.
`timescale 1ns/10ps
`default_nettype none
`include "cie_regs.svh"

module cie_core_test;
	logic clk, rst, start, int_pending;
	logic [4:0] op_code;
	logic [7:0] mem_rdata, imm, acc, mem_wdata;
	logic [2:0] bit_sel;
	logic [12:0] stack_top, pc, pc_before;
	logic [5:0] flags;
	logic gie, mem_we, stack_pop, int_service, busy, done;
	int err_total = 0;
	int samples_checked = 0;

	cie_core cie_core_i (.clk(clk), .rst(rst), .start(start),
		.op_code(op_code), .mem_rdata(mem_rdata), .imm(imm),
		.bit_sel(bit_sel), .stack_top(stack_top),
		.int_pending(int_pending), .acc(acc), .flags(flags), .pc(pc),
		.global_interrupt_enable(gie), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .stack_pop(stack_pop),
		.int_service(int_service), .busy(busy), .done(done));

	// ----------------------------------------
	// Clock, verdict and shared helpers
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] s, e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	// One accept edge; returns where the results have settled
	task automatic step(input logic [4:0] o, input logic [7:0] m, x,
		input logic [2:0] b);
		@(negedge clk);
		op_code = o;
		mem_rdata = m;
		imm = x;
		bit_sel = b;
		pc_before = pc;
		start = 1;
		@(negedge clk);
		start = 0;
	endtask

	// Memory strobe, accumulator, flags and pc advance
	task automatic res(input logic we, input logic [7:0] wd, a,
		input logic [5:0] f, input logic [12:0] d);
		chk("mem_we", mem_we, we);
		if (we) begin
			chk("mem_wdata", mem_wdata, wd);
		end
		chk("acc", acc, a);
		chk("flags", flags, f);
		chk("pc", pc, pc_before + d);
	endtask

	task automatic pl(input logic we, input logic [7:0] wd, a,
		input logic [5:0] f, input logic [12:0] d);
		res(we, wd, a, f, d);
		chk("done", done, 1);
		chk("busy", busy, 0);
	endtask

	// Skip forms: busy first, done only after the dummy cycle
	task automatic sk(input logic we, input logic [7:0] wd, a,
		input logic [5:0] f, input logic [12:0] d);
		res(we, wd, a, f, d);
		chk("busy", busy, 1);
		chk("done", done, 0);
		@(negedge clk);
		chk("done", done, 1);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_or();
		step(`CIE_OP_NOP, 8'h5a, 8'h5a, 3'h0);
		pl(0, 8'h00, 8'h00, 6'h00, 13'h0001);
		step(`CIE_OP_OR_IMM, 8'hff, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h00, 6'h04, 13'h0001);
		step(`CIE_OP_OR_MEM, 8'h5a, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h5a, 6'h00, 13'h0001);
		step(`CIE_OP_OR_INTO_MEM, 8'h81, 8'h00, 3'h0);
		pl(1, 8'hdb, 8'h5a, 6'h00, 13'h0001);
	endtask

	task automatic t_rot();
		step(`CIE_OP_ROTL, 8'h81, 8'h00, 3'h0);
		pl(1, 8'h03, 8'h5a, 6'h00, 13'h0001);
		step(`CIE_OP_ROTL_ACC, 8'h81, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h03, 6'h00, 13'h0001);
		step(`CIE_OP_ROTLC, 8'h81, 8'h00, 3'h0);
		pl(1, 8'h02, 8'h03, 6'h01, 13'h0001);
		step(`CIE_OP_ROTLC_ACC, 8'h00, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h01, 6'h00, 13'h0001);
		step(`CIE_OP_ROTR, 8'h81, 8'h00, 3'h0);
		pl(1, 8'hc0, 8'h01, 6'h00, 13'h0001);
		step(`CIE_OP_ROTR_ACC, 8'h01, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h80, 6'h00, 13'h0001);
		// Zero result must not touch the zero flag here
		step(`CIE_OP_ROTRC, 8'h01, 8'h00, 3'h0);
		pl(1, 8'h00, 8'h80, 6'h01, 13'h0001);
		step(`CIE_OP_ROTRC_ACC, 8'h02, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h81, 6'h00, 13'h0001);
	endtask

	task automatic t_sub();
		stack_top = 13'h0123;
		step(`CIE_OP_LEAVE_SUB_LIT, 8'h00, 8'h10, 3'h0);
		pl(0, 8'h00, 8'h10, 6'h00, 13'h0123 - pc_before);
		chk("stack_pop", stack_pop, 1);
		step(`CIE_OP_SUB_MEM, 8'h10, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h00, 6'h27, 13'h0001);
		step(`CIE_OP_SBB_IMM, 8'h00, 8'h01, 3'h0);
		pl(0, 8'h00, 8'hff, 6'h10, 13'h0001);
		// Signed wrap with the borrow term pushing past the limit
		step(`CIE_OP_SBB_MEM, 8'h7f, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h7f, 6'h19, 13'h0001);
		step(`CIE_OP_SBB_INTO_MEM, 8'h7f, 8'h00, 3'h0);
		pl(1, 8'h00, 8'h7f, 6'h07, 13'h0001);
	endtask

	task automatic t_ret();
		stack_top = 13'h0456;
		step(`CIE_OP_LEAVE_SUB, 8'h00, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h7f, 6'h07, 13'h0456 - pc_before);
		chk("gie", gie, 0);
		stack_top = 13'h1222;
		step(`CIE_OP_LEAVE_INT, 8'h00, 8'h00, 3'h0);
		pl(0, 8'h00, 8'h7f, 6'h07, 13'h1222 - pc_before);
		chk("gie", gie, 1);
		chk("int_service", int_service, 0);
		int_pending = 1;
		step(`CIE_OP_LEAVE_INT, 8'h00, 8'h00, 3'h0);
		chk("int_service", int_service, 1);
		chk("stack_pop", stack_pop, 1);
		int_pending = 0;
	endtask

	task automatic t_skip();
		step(`CIE_OP_DEC_SKIP, 8'h01, 8'h00, 3'h0);
		sk(1, 8'h00, 8'h7f, 6'h07, 13'h0002);
		// A start held into the dummy cycle must be ignored
		@(negedge clk);
		op_code = `CIE_OP_DEC_SKIP;
		mem_rdata = 8'h02;
		pc_before = pc;
		start = 1;
		@(negedge clk);
		op_code = `CIE_OP_OR_IMM;
		imm = 8'hff;
		sk(1, 8'h01, 8'h7f, 6'h07, 13'h0001);
		start = 0;
		chk("acc", acc, 8'h7f);
		chk("pc", pc, pc_before + 13'h0001);
		step(`CIE_OP_DEC_SKIP_ACC, 8'h01, 8'h00, 3'h0);
		sk(0, 8'h00, 8'h00, 6'h07, 13'h0002);
		step(`CIE_OP_INC_SKIP, 8'hff, 8'h00, 3'h0);
		sk(1, 8'h00, 8'h00, 6'h07, 13'h0002);
		step(`CIE_OP_INC_SKIP_ACC, 8'h05, 8'h00, 3'h0);
		sk(0, 8'h00, 8'h06, 6'h07, 13'h0001);
		step(`CIE_OP_BIT_SKIP, 8'h08, 8'h00, 3'h3);
		sk(0, 8'h00, 8'h06, 6'h07, 13'h0002);
		step(`CIE_OP_BIT_SKIP, 8'hf7, 8'h00, 3'h3);
		sk(0, 8'h00, 8'h06, 6'h07, 13'h0001);
		step(`CIE_OP_NZ_SKIP, 8'h00, 8'h00, 3'h0);
		sk(1, 8'h00, 8'h06, 6'h07, 13'h0001);
		step(`CIE_OP_NZ_SKIP, 8'h33, 8'h00, 3'h0);
		sk(1, 8'h33, 8'h06, 6'h07, 13'h0002);
	endtask

	task automatic t_set();
		step(`CIE_OP_SET_BYTE, 8'h12, 8'h00, 3'h0);
		pl(1, 8'hff, 8'h06, 6'h07, 13'h0001);
		step(`CIE_OP_SET_BIT, 8'h10, 8'h00, 3'h0);
		pl(1, 8'h11, 8'h06, 6'h07, 13'h0001);
		step(`CIE_OP_SET_BIT, 8'h00, 8'h00, 3'h7);
		pl(1, 8'h80, 8'h06, 6'h07, 13'h0001);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst = 1;
		start = 0;
		int_pending = 0;
		op_code = 5'h00;
		mem_rdata = 8'h00;
		imm = 8'h00;
		bit_sel = 3'h0;
		stack_top = 13'h0000;
		pc_before = 13'h0000;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 0;
		chk("acc", acc, 8'h00);
		chk("flags", flags, 6'h00);
		chk("pc", pc, 13'h0000);
		chk("gie", gie, 0);
		t_or();
		t_rot();
		t_sub();
		t_ret();
		t_skip();
		t_set();
		conclude();
	end

	// Whole run needs about 80 cycles; hang cut well beyond
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
